//--- logic/bpc_pkg.sv
// constants, register map and pin bundles for the bus pin configuration block
// assumes one 200 MHz system clock and a plain strobe register port
`default_nettype none

package bpc_pkg;

   // ==================================================================
   // register map (word aligned byte addresses)
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  OFS_BUS_CFG     = 8'h00;
   localparam logic [7:0]  OFS_BUS_CFG2    = 8'h04;
   localparam logic [7:0]  OFS_INT_STAT    = 8'h08;
   localparam logic [7:0]  OFS_INT_MASK    = 8'h0c;

   // ==================================================================
   // bus_config fields
   localparam int          BIT_EXT_EN      = 15;
   localparam int          BIT_RSVD        = 14;
   localparam int          BIT_RETRY_LATCH = 13;
   localparam int          BIT_PO_HI       = 12;
   localparam int          BIT_PO_LO       = 11;
   localparam int          BIT_SYNC_BUS    = 10;
   localparam int          BIT_USR_HI      = 9;
   localparam int          BIT_USR_LO      = 8;
   // bits software may change; 14 is fixed zero, 9:8 hold the strap
   localparam logic [15:0] CFG_WR_MASK     = 16'hbcff;
   localparam logic [15:0] CFG_RST         = 16'h0000;
   // second_bus_config: user output levels in 15:12
   localparam int          EXT_OUT_MSB     = 15;
   localparam int          EXT_OUT_LSB     = 12;
   localparam logic [15:0] CFG2_RST        = 16'h0000;

   // ==================================================================
   // interrupt status / mask layout
   localparam int          INT_W           = 2;
   localparam int          BIT_RETRY_FLAG  = 0;
   localparam int          BIT_RETRY_DONE  = 1;
   localparam logic [1:0]  INT_RST         = 2'h0;

   // ==================================================================
   // timing and style encodings
   localparam int          STRAP_WAIT      = 3;   // cycles for strap to pass the synchroniser
   localparam logic        STYLE_TERM      = 1'h1;

   // four repurposable pins, msb first: tx data, loopback, rx clock, rx data
   typedef struct packed {
      logic txd;
      logic loopback_pin;
      logic rx_clock_pin;
      logic rxd;
   } bpc_endec_t;

   typedef enum logic [1:0] {
      RT_IDLE = 2'b00,
      RT_WAIT = 2'b01,
      RT_GO   = 2'b10
   } bpc_retry_st_t;

endpackage

`default_nettype wire

//--- logic/bpc_bus_pin_config_retry.sv
// pin multiplexing, programmable outputs and bus retry handling
// assumes master grant inputs come from same-clock logic; pins are raw and
// pass a three stage synchroniser before use
//
// Added by the designer: the strobed register port and the register offsets.
`default_nettype none

module bpc_bus_pin_config_retry #(
   parameter int SYNC_STAGES = 3
) (
   // clock and reset
   input  wire logic                      I_CLK_SYS,
   input  wire logic                      I_RST_N,
   // register port
   input  wire logic [bpc_pkg::ADDR_W-1:0] I_REG_ADDR,
   input  wire logic [bpc_pkg::DATA_W-1:0] I_REG_WDATA,
   input  wire logic                      I_REG_WR,
   input  wire logic                      I_REG_RD,
   output logic      [bpc_pkg::DATA_W-1:0] O_REG_RDATA,
   output logic                           O_IRQ,
   // bus master state and style
   input  wire logic                      I_HOLD_ACK,
   input  wire logic                      I_GRANT_ACK_N,
   input  wire logic                      I_BUS_STYLE_SELECT,
   // dma engine handshake
   input  wire logic                      I_DMA_BUSY,
   output logic                           O_DMA_STOP,
   output logic                           O_DMA_RETRY,
   // internal encoder/decoder side
   input  wire bpc_pkg::bpc_endec_t       I_ENDEC_OUT,
   output bpc_pkg::bpc_endec_t            O_ENDEC_IN,
   output logic                           O_ENDEC_TX_CLOCK,
   output logic                           O_SYNC_TERMINATION,
   // repurposable pins
   input  wire bpc_pkg::bpc_endec_t       I_ENDEC_PIN,
   output bpc_pkg::bpc_endec_t            O_ENDEC_PIN,
   output bpc_pkg::bpc_endec_t            O_ENDEC_PIN_OE,
   // tx clock / termination pin, retry pin
   input  wire logic                      I_TX_CLOCK_PIN,
   input  wire logic                      I_BUS_RETRY_IN,
   // user pins (strap at reset, outputs as master)
   input  wire logic [1:0]                I_USER_PIN,
   output logic      [1:0]                O_USER_PIN,
   output logic      [1:0]                O_USER_PIN_OE
);

   // ==================================================================
   // synchronisers for pin inputs
   // ==================================================================
   localparam int NSYNC = 8;   // 4 endec pins, tx clock, retry, 2 user pins

   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [NSYNC-1:0] sync3_ff;
   logic [NSYNC-1:0] pin_ok_ff;   // value that both late stages agreed on

   assign pin_raw = {I_USER_PIN, I_BUS_RETRY_IN, I_TX_CLOCK_PIN, I_ENDEC_PIN};

   // stage one feeds only stage two, so metastability stays contained
   generate
      for (genvar g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
            if (!I_RST_N) begin
               sync1_ff[g]  <= 1'h0;
               sync2_ff[g]  <= 1'h0;
               sync3_ff[g]  <= 1'h0;
               pin_ok_ff[g] <= 1'h0;
            end else begin
               sync1_ff[g] <= pin_raw[g];
               sync2_ff[g] <= sync1_ff[g];
               sync3_ff[g] <= sync2_ff[g];
               if (sync2_ff[g] == sync3_ff[g]) begin
                  pin_ok_ff[g] <= sync3_ff[g];
               end
            end
         end
      end
   endgenerate

   wire bpc_pkg::bpc_endec_t endec_pin_s = pin_ok_ff[3:0];
   wire logic                tx_clock_s  = pin_ok_ff[4];
   wire logic                retry_s     = pin_ok_ff[5];
   wire logic [1:0]          user_pin_s  = pin_ok_ff[7:6];

   // ==================================================================
   // registers
   // ==================================================================
   logic [bpc_pkg::DATA_W-1:0] bus_config_ff;
   logic [bpc_pkg::DATA_W-1:0] second_bus_config_ff;
   logic [bpc_pkg::INT_W-1:0]  int_stat_ff;
   logic [bpc_pkg::INT_W-1:0]  int_mask_ff;
   logic                       cfg_written_ff;   // endec pins float until first config write
   logic [1:0]                 strap_ff;
   logic [2:0]                 strap_cnt_ff;
   logic                       strap_done_ff;

   // address decode
   wire logic sel_cfg  = (I_REG_ADDR == bpc_pkg::OFS_BUS_CFG);
   wire logic sel_cfg2 = (I_REG_ADDR == bpc_pkg::OFS_BUS_CFG2);
   wire logic sel_stat = (I_REG_ADDR == bpc_pkg::OFS_INT_STAT);
   wire logic sel_mask = (I_REG_ADDR == bpc_pkg::OFS_INT_MASK);
   wire logic wr_cfg   = I_REG_WR && sel_cfg;
   wire logic wr_cfg2  = I_REG_WR && sel_cfg2;
   wire logic wr_stat  = I_REG_WR && sel_stat;
   wire logic wr_mask  = I_REG_WR && sel_mask;

   // configuration fields
   wire logic ext_en      = bus_config_ff[bpc_pkg::BIT_EXT_EN];
   wire logic retry_latch = bus_config_ff[bpc_pkg::BIT_RETRY_LATCH];
   wire logic sync_bus    = bus_config_ff[bpc_pkg::BIT_SYNC_BUS];
   wire logic [1:0] prog_out = {bus_config_ff[bpc_pkg::BIT_PO_HI],
                                bus_config_ff[bpc_pkg::BIT_PO_LO]};
   wire logic [3:0] ext_user_out =
      second_bus_config_ff[bpc_pkg::EXT_OUT_MSB:bpc_pkg::EXT_OUT_LSB];
   wire logic bus_master  = I_HOLD_ACK || !I_GRANT_ACK_N;

   // bit 14 is held at zero whatever is written; the strap bits are read only
   wire logic [15:0] nxt_bus_config =
      (I_REG_WDATA & bpc_pkg::CFG_WR_MASK) | {6'h00, strap_ff, 8'h00};

   // bus_config: hardware reset clears everything that steers pins
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         bus_config_ff  <= bpc_pkg::CFG_RST;
         cfg_written_ff <= 1'h0;
      end else if (wr_cfg) begin
         bus_config_ff  <= nxt_bus_config;
         cfg_written_ff <= 1'h1;
      end else if (!strap_done_ff) begin
         bus_config_ff[bpc_pkg::BIT_USR_HI:bpc_pkg::BIT_USR_LO] <= user_pin_s;
      end
   end

   // second_bus_config and mask: plain storage
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         second_bus_config_ff <= bpc_pkg::CFG2_RST;
         int_mask_ff          <= bpc_pkg::INT_RST;
      end else begin
         if (wr_cfg2) second_bus_config_ff <= I_REG_WDATA;
         if (wr_mask) int_mask_ff <= I_REG_WDATA[bpc_pkg::INT_W-1:0];
      end
   end

   // strap capture once the pins have passed synchroniser and agree stage
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         strap_cnt_ff  <= 3'h0;
         strap_done_ff <= 1'h0;
         strap_ff      <= 2'h0;
      end else if (!strap_done_ff) begin
         strap_ff <= user_pin_s;
         if (strap_cnt_ff == 3'(bpc_pkg::STRAP_WAIT + 1)) begin
            strap_done_ff <= 1'h1;
         end else begin
            strap_cnt_ff <= strap_cnt_ff + 3'h1;
         end
      end
   end

   // ==================================================================
   // bus retry sequencing
   // ==================================================================
   bpc_pkg::bpc_retry_st_t rt_st_ff;
   bpc_pkg::bpc_retry_st_t nxt_rt_st;
   logic                   retry_seen;
   logic                   retry_clear_ok;

   // a retry counts only while a dma access is under way
   assign retry_seen     = retry_s && I_DMA_BUSY;
   // latched mode also waits for software to clear the status flag
   assign retry_clear_ok = !retry_s &&
                           (!retry_latch || !int_stat_ff[bpc_pkg::BIT_RETRY_FLAG]);

   always_comb begin
      nxt_rt_st = rt_st_ff;
      case (rt_st_ff)
         bpc_pkg::RT_IDLE: begin
            if (retry_seen) nxt_rt_st = bpc_pkg::RT_WAIT;
         end
         bpc_pkg::RT_WAIT: begin
            if (retry_clear_ok) nxt_rt_st = bpc_pkg::RT_GO;
         end
         bpc_pkg::RT_GO: begin
            nxt_rt_st = bpc_pkg::RT_IDLE;
         end
         default: begin
            nxt_rt_st = bpc_pkg::RT_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rt_st_ff <= bpc_pkg::RT_IDLE;
      end else begin
         rt_st_ff <= nxt_rt_st;
      end
   end

   // ==================================================================
   // interrupt status: sticky, write one to clear, set beats clear
   // ==================================================================
   logic [bpc_pkg::INT_W-1:0] int_set;
   logic [bpc_pkg::INT_W-1:0] int_clr;
   logic [bpc_pkg::INT_W-1:0] nxt_int_stat;

   assign int_set[bpc_pkg::BIT_RETRY_FLAG] = (rt_st_ff == bpc_pkg::RT_IDLE) && retry_seen;
   assign int_set[bpc_pkg::BIT_RETRY_DONE] = (nxt_rt_st == bpc_pkg::RT_GO);
   assign int_clr      = wr_stat ? I_REG_WDATA[bpc_pkg::INT_W-1:0] : bpc_pkg::INT_RST;
   assign nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         int_stat_ff <= bpc_pkg::INT_RST;
         O_IRQ       <= 1'h0;
      end else begin
         int_stat_ff <= nxt_int_stat;
         O_IRQ       <= |(nxt_int_stat & int_mask_ff);
      end
   end

   // ==================================================================
   // read port: data stands one cycle after the strobe, zero elsewhere
   // ==================================================================
   logic [bpc_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      if (sel_cfg) begin
         rd_mux = bus_config_ff;
      end else if (sel_cfg2) begin
         rd_mux = second_bus_config_ff;
      end else if (sel_stat) begin
         rd_mux = {{(bpc_pkg::DATA_W-bpc_pkg::INT_W){1'b0}}, int_stat_ff};
      end else if (sel_mask) begin
         rd_mux = {{(bpc_pkg::DATA_W-bpc_pkg::INT_W){1'b0}}, int_mask_ff};
      end else begin
         rd_mux = 16'h0000;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REG_RDATA <= 16'h0000;
      end else begin
         O_REG_RDATA <= I_REG_RD ? rd_mux : 16'h0000;
      end
   end

   // ==================================================================
   // pin multiplexing
   // ==================================================================
   // extended mode drives only while master; normal mode drives only the
   // two encoder outputs, the rx pair stays an input
   wire logic ext_drive  = cfg_written_ff && ext_en && bus_master;
   wire logic norm_mode  = cfg_written_ff && !ext_en;
   wire logic term_use   = ext_en && !sync_bus && bus_master &&
                           (I_BUS_STYLE_SELECT == bpc_pkg::STYLE_TERM);

   bpc_pkg::bpc_endec_t nxt_pin;
   bpc_pkg::bpc_endec_t nxt_pin_oe;
   bpc_pkg::bpc_endec_t nxt_endec_in;

   always_comb begin
      nxt_pin      = '0;
      nxt_pin_oe   = '0;
      nxt_endec_in = '0;
      if (ext_drive) begin
         nxt_pin    = ext_user_out;
         nxt_pin_oe = 4'hf;
      end else if (norm_mode) begin
         nxt_pin.txd      = I_ENDEC_OUT.txd;
         nxt_pin.loopback_pin      = I_ENDEC_OUT.loopback_pin;
         nxt_pin_oe.txd   = 1'h1;
         nxt_pin_oe.loopback_pin   = 1'h1;
         nxt_endec_in.rx_clock_pin = endec_pin_s.rx_clock_pin;
         nxt_endec_in.rxd = endec_pin_s.rxd;
      end
   end

   // every pin-facing output is registered to keep glitches off the board
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ENDEC_PIN        <= '0;
         O_ENDEC_PIN_OE     <= '0;
         O_ENDEC_IN         <= '0;
         O_ENDEC_TX_CLOCK   <= 1'h0;
         O_SYNC_TERMINATION <= 1'h0;
      end else begin
         O_ENDEC_PIN        <= nxt_pin;
         O_ENDEC_PIN_OE     <= nxt_pin_oe;
         O_ENDEC_IN         <= nxt_endec_in;
         O_ENDEC_TX_CLOCK   <= norm_mode && tx_clock_s;
         O_SYNC_TERMINATION <= cfg_written_ff && term_use && tx_clock_s;
      end
   end

   // user pins: programmable outputs only while master, else left to strap
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_USER_PIN    <= 2'h0;
         O_USER_PIN_OE <= 2'h0;
      end else begin
         O_USER_PIN    <= bus_master ? prog_out : 2'h0;
         O_USER_PIN_OE <= bus_master ? 2'h3 : 2'h0;
      end
   end

   // dma handshake: stop after the current access, then one retry pulse
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_DMA_STOP  <= 1'h0;
         O_DMA_RETRY <= 1'h0;
      end else begin
         O_DMA_STOP  <= (nxt_rt_st == bpc_pkg::RT_WAIT);
         O_DMA_RETRY <= (nxt_rt_st == bpc_pkg::RT_GO);
      end
   end

endmodule

`default_nettype wire

//--- test/bpc_sva.sv
// assertions on pin muxing, user outputs and retry hold-off
// assumes it is bound onto bpc_bus_pin_config_retry; one clock domain
`default_nettype none

module bpc_sva (
   // clock, reset, register port
   input wire logic                       I_CLK_SYS,
   input wire logic                       I_RST_N,
   input wire logic [bpc_pkg::ADDR_W-1:0] I_REG_ADDR,
   input wire logic [bpc_pkg::DATA_W-1:0] I_REG_WDATA,
   input wire logic                       I_REG_WR,
   // master, style, retry
   input wire logic                       I_HOLD_ACK,
   input wire logic                       I_GRANT_ACK_N,
   input wire logic                       I_BUS_STYLE_SELECT,
   input wire logic                       I_BUS_RETRY_IN,
   input wire logic                       O_DMA_STOP,
   input wire logic                       O_DMA_RETRY,
   // pins
   input wire bpc_pkg::bpc_endec_t        I_ENDEC_OUT,
   input wire bpc_pkg::bpc_endec_t        O_ENDEC_PIN,
   input wire bpc_pkg::bpc_endec_t        O_ENDEC_PIN_OE,
   input wire logic                       O_SYNC_TERMINATION,
   input wire logic [1:0]                 O_USER_PIN,
   input wire logic [1:0]                 O_USER_PIN_OE
);
   // ==================================================================
   // shadow of software writes
   logic [15:0] cfg_ff;
   logic [15:0] cfg2_ff;
   logic        written_ff;
   logic        up_ff;
   logic        clr_ff;
   wire         master  = I_HOLD_ACK | ~I_GRANT_ACK_N;
   wire         wr_cfg  = I_REG_WR && (I_REG_ADDR == bpc_pkg::OFS_BUS_CFG);
   wire         wr_cfg2 = I_REG_WR && (I_REG_ADDR == bpc_pkg::OFS_BUS_CFG2);
   wire         clr_now = I_REG_WR && (I_REG_ADDR == bpc_pkg::OFS_INT_STAT) && I_REG_WDATA[0];
   wire         term_ok = written_ff && cfg_ff[15] && !cfg_ff[10] && master
                          && (I_BUS_STYLE_SELECT == bpc_pkg::STYLE_TERM);

   // clr_ff: status clear seen in this hold
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cfg_ff     <= 16'h0000;
         cfg2_ff    <= 16'h0000;
         written_ff <= 1'b0;
         up_ff      <= 1'b0;
         clr_ff     <= 1'b0;
      end else begin
         cfg_ff     <= wr_cfg ? I_REG_WDATA : cfg_ff;
         cfg2_ff    <= wr_cfg2 ? I_REG_WDATA : cfg2_ff;
         written_ff <= written_ff | wr_cfg;
         up_ff      <= 1'b1;
         clr_ff     <= O_DMA_STOP & (clr_ff | clr_now);
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);

   // six high samples keep the synced retry high
   sequence retry_held_s;
      I_BUS_RETRY_IN [*6] ##0 O_DMA_STOP;
   endsequence
   sequence resume_s;
      !O_DMA_STOP && $past(O_DMA_STOP) ##1 !O_DMA_RETRY;
   endsequence

   float_at_reset_a : assert property (
      !written_ff |=> (O_ENDEC_PIN_OE == 4'h0) && !O_SYNC_TERMINATION)
      else $error("pins driven before first config write");
   ext_master_a : assert property (
      written_ff && cfg_ff[15] && master |=>
         (O_ENDEC_PIN_OE == 4'hf) && (O_ENDEC_PIN == $past(cfg2_ff[15:12])))
      else $error("ext user outputs wrong");
   ext_idle_a : assert property (
      written_ff && cfg_ff[15] && !master |=> O_ENDEC_PIN_OE == 4'h0)
      else $error("user outputs driven while not master");
   normal_mode_a : assert property (
      written_ff && !cfg_ff[15] |=>
         (O_ENDEC_PIN_OE == 4'hc) && (O_ENDEC_PIN[3:2] == $past(I_ENDEC_OUT[3:2])))
      else $error("encoder pins wrong in normal mode");
   term_off_a : assert property (
      !term_ok |=> !O_SYNC_TERMINATION)
      else $error("termination outside its mode");
   user_pin_a : assert property (
      up_ff |=> (O_USER_PIN_OE == {2{$past(master)}})
         && (!$past(master) || (O_USER_PIN == $past(cfg_ff[12:11]))))
      else $error("user pin level or enable wrong");
   resume_pulse_a : assert property (
      O_DMA_RETRY |-> resume_s)
      else $error("retry pulse not at end of hold");
   drop_pulse_a : assert property (
      $fell(O_DMA_STOP) |-> O_DMA_RETRY)
      else $error("hold ended without retry pulse");
   retry_hold_a : assert property (
      retry_held_s |=> O_DMA_STOP)
      else $error("hold released while retry still high");
   latched_hold_a : assert property (
      O_DMA_STOP && cfg_ff[13] && !clr_ff && !clr_now |=> O_DMA_STOP)
      else $error("latched hold released early");
endmodule

bind bpc_bus_pin_config_retry bpc_sva u_bpc_sva (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
   .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_HOLD_ACK(I_HOLD_ACK),
   .I_GRANT_ACK_N(I_GRANT_ACK_N), .I_BUS_STYLE_SELECT(I_BUS_STYLE_SELECT),
   .I_BUS_RETRY_IN(I_BUS_RETRY_IN), .O_DMA_STOP(O_DMA_STOP), .O_DMA_RETRY(O_DMA_RETRY),
   .I_ENDEC_OUT(I_ENDEC_OUT), .O_ENDEC_PIN(O_ENDEC_PIN), .O_ENDEC_PIN_OE(O_ENDEC_PIN_OE),
   .O_SYNC_TERMINATION(O_SYNC_TERMINATION), .O_USER_PIN(O_USER_PIN),
   .O_USER_PIN_OE(O_USER_PIN_OE)
);

`default_nettype wire

//--- test/bpc_arb_model.sv
// bus arbiter and dma requester on the far side
// assumes grant shows on hold_ack in style 0 and on grant_ack_n in style 1
`default_nettype none

module bpc_arb_model (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // bench controls
   input  wire logic i_want_bus,
   input  wire logic i_fast,
   input  wire logic i_style,
   // block side
   input  wire logic i_dma_stop,
   input  wire logic i_dma_retry,
   output logic      o_hold_ack,
   output logic      o_grant_ack_n,
   output logic      o_dma_busy
);
   // ==================================================================
   // grant and access state
   logic [1:0] dly_ff;
   logic       granted_ff;
   logic       held_ff;
   logic       busy_ff;

   // grant polarity follows the bus style in use
   assign o_hold_ack    = granted_ff & ~i_style;
   assign o_grant_ack_n = ~(granted_ff & i_style);
   assign o_dma_busy    = busy_ff;

   // slow grant comes three cycles late
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dly_ff     <= 2'h0;
         granted_ff <= 1'b0;
         held_ff    <= 1'b0;
         busy_ff    <= 1'b0;
      end else begin
         dly_ff     <= !i_want_bus ? 2'h0 : (dly_ff == 2'h3) ? dly_ff : dly_ff + 2'h1;
         granted_ff <= i_want_bus && (i_fast || (dly_ff == 2'h3));
         // a stopped access stays held until the retry pulse
         held_ff    <= i_dma_stop | (held_ff & ~i_dma_retry);
         busy_ff    <= granted_ff & ~i_dma_stop & (~held_ff | i_dma_retry);
      end
   end
endmodule

`default_nettype wire

//--- test/bpc_bus_pin_config_retry_tb_top.sv
// self-checking bench for the pin config and retry block
// assumes package, design, checker and model compile first
`default_nettype none

module bpc_bus_pin_config_retry_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(nm, exp, got) \
      begin \
         total_checks++; \
         if ((got) !== (exp)) begin \
            fail_count++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
         end \
      end

   // ==================================================================
   // signals
   int                  fail_count   = 0;
   int                  total_checks = 0;
   logic                clk = 1'b0;
   logic                rst_n, wr, rd, want_bus, fast, style, tx_pin, retry_pin;
   logic [7:0]          addr;
   logic [15:0]         wdata, rdata;
   logic                irq, hold_ack, grant_n, dma_busy, dma_stop, dma_retry, tx_clk_o, term;
   logic [1:0]          strap, user_i, user_o, user_oe;
   bpc_pkg::bpc_endec_t endec_out, endec_in, ext_pin, pin_i, pin_o, pin_oe;

   // pin levels: driver wins, else outside source
   assign pin_i  = (pin_oe & pin_o) | (~pin_oe & ext_pin);
   assign user_i = (user_oe & user_o) | (~user_oe & strap);
   always #2.5 clk = ~clk;

   bpc_bus_pin_config_retry u_bpc_bus_pin_config_retry (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_IRQ(irq),
      .I_HOLD_ACK(hold_ack), .I_GRANT_ACK_N(grant_n), .I_BUS_STYLE_SELECT(style),
      .I_DMA_BUSY(dma_busy), .O_DMA_STOP(dma_stop), .O_DMA_RETRY(dma_retry),
      .I_ENDEC_OUT(endec_out), .O_ENDEC_IN(endec_in), .O_ENDEC_TX_CLOCK(tx_clk_o),
      .O_SYNC_TERMINATION(term), .I_ENDEC_PIN(pin_i), .O_ENDEC_PIN(pin_o),
      .O_ENDEC_PIN_OE(pin_oe), .I_TX_CLOCK_PIN(tx_pin), .I_BUS_RETRY_IN(retry_pin),
      .I_USER_PIN(user_i), .O_USER_PIN(user_o), .O_USER_PIN_OE(user_oe));

   bpc_arb_model u_bpc_arb_model (
      .i_clk(clk), .i_rst_n(rst_n), .i_want_bus(want_bus), .i_fast(fast),
      .i_style(style), .i_dma_stop(dma_stop), .i_dma_retry(dma_retry),
      .o_hold_ack(hold_ack), .o_grant_ack_n(grant_n), .o_dma_busy(dma_busy));

   // ==================================================================
   // register port tasks
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      `CHK(nm, exp, rdata)
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==================================================================
   // scenarios
   task automatic t_reset();
      wait_cyc(6);
      `CHK("oe at reset", 4'h0, pin_oe)
      `CHK("term at reset", 1'b0, term)
      reg_rd(bpc_pkg::OFS_BUS_CFG, 16'h0200, "cfg reset");
      reg_rd(8'h10, 16'h0000, "unmapped");
      reg_rd(bpc_pkg::OFS_INT_STAT, 16'h0000, "status reset");
   endtask

   task automatic t_normal();
      @(posedge clk);
      endec_out <= 4'h9;
      ext_pin   <= 4'h2;
      tx_pin    <= 1'b1;
      reg_wr(bpc_pkg::OFS_BUS_CFG, 16'h00a5);
      wait_cyc(6);
      `CHK("normal oe", 4'hc, pin_oe)
      `CHK("tx data out", 2'h2, pin_o[3:2])
      `CHK("rx pins in", 2'h2, endec_in[1:0])
      `CHK("tx clock in", 1'b1, tx_clk_o)
      `CHK("no term", 1'b0, term)
      reg_rd(bpc_pkg::OFS_BUS_CFG, 16'h02a5, "cfg readback");
      reg_wr(bpc_pkg::OFS_BUS_CFG, 16'hbcff); // strap bits 9:8 stay read only
      reg_rd(bpc_pkg::OFS_BUS_CFG, 16'hbeff, "cfg write mask");
      @(posedge clk);
      tx_pin <= 1'b0;
   endtask

   task automatic t_ext();
      reg_wr(bpc_pkg::OFS_BUS_CFG2, 16'ha000);
      reg_wr(bpc_pkg::OFS_BUS_CFG, 16'h9800);
      wait_cyc(3);
      `CHK("float oe", 4'h0, pin_oe)
      `CHK("user oe idle", 2'h0, user_oe)
      @(posedge clk);
      want_bus <= 1'b1;
      wait_cyc(8);
      `CHK("ext oe", 4'hf, pin_oe)
      `CHK("ext level", 4'ha, pin_o)
      `CHK("user level", 2'h3, user_o)
      @(posedge clk);
      tx_pin <= 1'b1;
      wait_cyc(6);
      `CHK("term style 0", 1'b0, term)
      @(posedge clk);
      style <= 1'b1;
      wait_cyc(6);
      `CHK("term on", 1'b1, term)
      reg_wr(bpc_pkg::OFS_BUS_CFG, 16'h8c00);
      wait_cyc(3);
      `CHK("term sync bus", 1'b0, term)
      `CHK("user level 01", 2'h1, user_o)
      @(posedge clk);
      want_bus <= 1'b0;
      style    <= 1'b0;
      tx_pin   <= 1'b0;
      wait_cyc(3);
      `CHK("ext released", 4'h0, pin_oe)
   endtask

   // latch selects the hold-off mode
   task automatic t_retry(input logic latch);
      reg_wr(bpc_pkg::OFS_INT_MASK, 16'h0001);
      reg_wr(bpc_pkg::OFS_BUS_CFG, {2'h0, latch, 13'h0000});
      @(posedge clk);
      want_bus <= 1'b1;
      fast     <= 1'b1;
      wait_cyc(4);
      `CHK("dma busy", 1'b1, dma_busy)
      @(posedge clk);
      retry_pin <= 1'b1;
      for (int i = 0; i < 20 && dma_stop !== 1'b1; i++) wait_cyc(1);
      `CHK("stop", 1'b1, dma_stop)
      wait_cyc(8);
      `CHK("stop held", 1'b1, dma_stop)
      `CHK("irq raised", 1'b1, irq)
      @(posedge clk);
      retry_pin <= 1'b0;
      if (latch) begin
         wait_cyc(12);
         `CHK("latched hold", 1'b1, dma_stop)
         reg_wr(bpc_pkg::OFS_INT_STAT, 16'h0001);
      end
      for (int i = 0; i < 20 && dma_retry !== 1'b1; i++) wait_cyc(1);
      `CHK("retry pulse", 1'b1, dma_retry)
      `CHK("stop dropped", 1'b0, dma_stop)
      wait_cyc(1);
      `CHK("pulse one cycle", 1'b0, dma_retry)
      reg_rd(bpc_pkg::OFS_INT_STAT, latch ? 16'h0002 : 16'h0003, "status");
      reg_wr(bpc_pkg::OFS_INT_STAT, 16'h0003);
      @(posedge clk);
      want_bus <= 1'b0;
      wait_cyc(2);
      `CHK("irq cleared", 1'b0, irq)
   endtask

   // ==================================================================
   // main sequence
   initial begin
      rst_n     <= 1'b0;
      wr        <= 1'b0;
      rd        <= 1'b0;
      addr      <= 8'h00;
      wdata     <= 16'h0000;
      want_bus  <= 1'b0;
      fast      <= 1'b0;
      style     <= 1'b0;
      tx_pin    <= 1'b0;
      retry_pin <= 1'b0;
      strap     <= 2'h2;
      endec_out <= 4'h0;
      ext_pin   <= 4'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_normal();
      t_ext();
      t_retry(1'b0);
      t_retry(1'b1);
      end_of_test();
   end

   // watchdog; scenarios take a few hundred cycles
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
